// ==== shared/pcs_pkg.sv ====
package pcs_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] PCS_CFG_OFS = 8'h00;
  localparam logic [7:0] PCS_STAT_OFS = 8'h04;

  // Configuration field positions.
  localparam int PCS_CFG_BYP_CODER = 0;
  localparam int PCS_CFG_BYP_SCR = 1;
  localparam int PCS_CFG_SPEED10 = 2;
  localparam int PCS_CFG_FIBER = 3;
  localparam logic [3:0] PCS_CFG_RST = 4'h0;

  // Status field positions; the three error bits are sticky.
  localparam int PCS_ST_SSD_ERR = 0;
  localparam int PCS_ST_ESD_ERR = 1;
  localparam int PCS_ST_CODE_ERR = 2;
  localparam int PCS_ST_LOSS_SYNC = 3;
  localparam int PCS_ST_IN_PKT = 4;
  localparam logic [2:0] PCS_ERR_RST = 3'h0;

  // Control symbols and substitute nibbles.
  localparam logic [4:0] PCS_SYM_IDLE = 5'h1F;
  localparam logic [4:0] PCS_SYM_J = 5'h18;
  localparam logic [4:0] PCS_SYM_K = 5'h11;
  localparam logic [4:0] PCS_SYM_T = 5'h0D;
  localparam logic [4:0] PCS_SYM_R = 5'h07;
  localparam logic [4:0] PCS_SYM_H = 5'h04;
  localparam logic [3:0] PCS_NIB_SSD = 4'h5;
  localparam logic [3:0] PCS_NIB_ZERO = 4'h0;

  // Clock rate and descrambler supervision.
  localparam int PCS_CLK_MHZ = 40;
  localparam int PCS_SYNC_WIN_US = 1000;
  localparam int PCS_SYNC_WIN_CYC = PCS_SYNC_WIN_US * PCS_CLK_MHZ;
  localparam int PCS_IDLE_RUN = 25;
  localparam int PCS_ACQ_MATCH = 30;
  localparam logic [10:0] PCS_SCR_SEED = 11'h5A5;

  // Manchester timing: lock transitions, preamble nibbles, then two counts in half-bit samples.
  localparam int PCS_LOCK_TRANS = 8;
  localparam int PCS_PRE_NIB_MIN = 6;
  localparam int PCS_SOI_HALF = 4;
  localparam int PCS_NOTRANS_END = 3;

  // Nibble going in from the controller.
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } pcs_tx_s;

  // Nibble going out to the controller.
  typedef struct packed {
    logic stb;
    logic dv;
    logic er;
    logic crs;
    logic [3:0] d;
  } pcs_rx_s;

  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} pcs_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_K, RX_DATA, RX_R} pcs_rx_e;

endpackage : pcs_pkg

// ==== verilog/pcs_coding_path.sv ====
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Function
// (RULE1) Map nibbles to fixed five-bit codes both ways.
// (RULE2) Idle is 11111, halt is 00100.
// (RULE3) Unknown codes decode to nibble zero.
// (RULE4) Start pair becomes two 0101 nibbles.
// (RULE5) End pair becomes two 0000 nibbles.
// (RULE6) Error flag aligned with the bad nibble.
// (RULE7) Each error kind sets its status bit.
// (RULE8) Manchester cell: inverted half, then true half.
// (RULE9) Start-of-idle pulse appended; gap not encoded.
// (RULE10) Coder bypass passes five-bit words unchanged.
// (RULE11) Bypassed receive passes raw words; carrier follows link.
// (RULE12) Fast receive clock follows line after squelch, equalizer.
// (RULE13) Fiber receive clock follows line on detect.
// (RULE14) Serial bits assembled into nibbles.
// (RULE15) Slow receive clock follows line on squelch.
// (RULE16) Slow lock quickly, keep six preamble nibbles.
// (RULE17) Fast copper symbols scrambled, per-channel seed.
// (RULE18) No scrambling slow; no descrambling on fiber.
// (RULE19) Scrambler bypass sends coder output directly.
// (RULE20) Descrambler bypass feeds receiver directly.
// (RULE21) Descrambler output aligned to word boundaries.
// (RULE22) Need 25 idle ones per window.
// (RULE23) Loss-of-sync bit while unsynchronised.
// (RULE24) Start pair, end pair and idle fill.
// (RULE25) Transmit error sends halt symbol.
module pcs_coding_path #(
  parameter int SYNC_WIN_CYC = pcs_pkg::PCS_SYNC_WIN_CYC,
  parameter logic [10:0] SCR_SEED = pcs_pkg::PCS_SCR_SEED
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // APB register port.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller side.
  input wire pcs_pkg::pcs_tx_s mac_tx,
  output logic mac_tx_ready,
  output pcs_pkg::pcs_rx_s mac_rx,
  // Line side, from the analog front end.
  input wire logic line_rx,
  input wire logic squelch_ok,
  input wire logic eq_settled,
  input wire logic fiber_signal_detect,
  input wire logic link_pass,
  // Line side, to the analog front end.
  output logic [4:0] tx_sym,
  output logic man_tx,
  output logic man_tx_oe,
  output logic rx_clk_from_line,
  output logic loss_of_sync
);
  import pcs_pkg::*;

  localparam int WIN_W = $clog2(SYNC_WIN_CYC + 1);

  if (SYNC_WIN_CYC < 2) begin : g_bad_win
    $error("sync window must be at least two cycles");
  end
  if (SCR_SEED == 11'h000) begin : g_bad_seed
    $error("scrambler seed must be nonzero");
  end

  // Five-bit code for a data nibble.
  function automatic logic [4:0] enc5(input logic [3:0] n);
    logic [4:0] s;
    s = 5'h1E;
    case (n)
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0A;
      4'h5: s = 5'h0B;
      4'h6: s = 5'h0E;
      4'h7: s = 5'h0F;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'hA: s = 5'h16;
      4'hB: s = 5'h17;
      4'hC: s = 5'h1A;
      4'hD: s = 5'h1B;
      4'hE: s = 5'h1C;
      4'hF: s = 5'h1D;
      default: s = 5'h1E;
    endcase
    return s;
  endfunction : enc5

  // Nibble and valid flag for a five-bit data code.
  function automatic logic [4:0] dec5(input logic [4:0] s);
    logic [4:0] r;
    r = {1'b0, PCS_NIB_ZERO};
    case (s)
      5'h1E: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0A: r = 5'h14;
      5'h0B: r = 5'h15;
      5'h0E: r = 5'h16;
      5'h0F: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1A;
      5'h17: r = 5'h1B;
      5'h1A: r = 5'h1C;
      5'h1B: r = 5'h1D;
      5'h1C: r = 5'h1E;
      5'h1D: r = 5'h1F;
      default: r = {1'b0, PCS_NIB_ZERO};
    endcase
    return r;
  endfunction : dec5

  //////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [3:0] cfg_q;
  logic [2:0] err_q, err_d, err_evt;
  logic [31:0] prdata_q;
  logic synced_q;
  pcs_rx_e rx_st_q;

  wire logic setup = psel && !penable;
  wire logic hit_cfg = (paddr == PCS_CFG_OFS);
  wire logic hit_stat = (paddr == PCS_STAT_OFS);
  wire logic wr_acc = psel && penable && pwrite;
  wire logic byp_coder = cfg_q[PCS_CFG_BYP_CODER];
  wire logic byp_scr = cfg_q[PCS_CFG_BYP_SCR];
  wire logic spd10 = cfg_q[PCS_CFG_SPEED10];
  wire logic fiber = cfg_q[PCS_CFG_FIBER];
  wire logic [2:0] w1c = (wr_acc && hit_stat) ? pwdata[2:0] : 3'h0;

  // Zero-wait slave; an unmapped address answers with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_cfg && !hit_stat;
  assign prdata = prdata_q;
  // A new event beats a clear in the same cycle. [RULE7]
  assign err_d = (err_q & ~w1c) | err_evt;

  // Read data is captured in the setup cycle so it is stable in access.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= PCS_CFG_RST;
      err_q <= PCS_ERR_RST;
      prdata_q <= 32'h0000_0000;
    end else begin
      err_q <= err_d;
      if (wr_acc && hit_cfg) begin
        cfg_q <= pwdata[3:0];
      end
      if (setup && hit_cfg) begin
        prdata_q <= {28'h000_0000, cfg_q};
      end else if (setup && hit_stat) begin
        prdata_q <= {27'h000_0000, rx_st_q != RX_IDLE, !synced_q, err_q};
      end else if (setup) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read.

  logic [4:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
    end else begin
      pin_s1_q <= {link_pass, fiber_signal_detect, eq_settled, squelch_ok,
                   line_rx};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire logic ln = pin_s2_q[0];
  wire logic sq = pin_s2_q[1];
  wire logic eq_ok = pin_s2_q[2];
  wire logic fsd = pin_s2_q[3];
  wire logic lpass = pin_s2_q[4];

  // Receive clock source select. [RULE12] [RULE13] [RULE15]
  wire logic clk_line_d = spd10 ? sq : (fiber ? fsd : (sq && eq_ok));

  //////////////////////////////////////////////////////////////////////////
  // Fast transmit: framing, coding and scrambling.

  pcs_tx_e tx_st_q, tx_st_d;
  logic [4:0] sym_d;
  logic [10:0] scr_q, scr_d;
  logic [4:0] scr_out;

  // Delimiters open and close each frame.
  always_comb begin
    tx_st_d = tx_st_q;
    sym_d = PCS_SYM_IDLE; // [RULE2] [RULE24]
    case (tx_st_q)
      TX_IDLE: begin
        if (mac_tx.en) begin
          sym_d = PCS_SYM_J; // [RULE24]
          tx_st_d = TX_K;
        end
      end
      TX_K: begin
        sym_d = PCS_SYM_K;
        tx_st_d = TX_DATA;
      end
      TX_DATA: begin
        if (!mac_tx.en) begin
          sym_d = PCS_SYM_T; // [RULE24]
          tx_st_d = TX_R;
        end else if (mac_tx.er) begin
          sym_d = PCS_SYM_H; // [RULE25]
        end else begin
          sym_d = enc5(mac_tx.d); // [RULE1] [RULE3]
        end
      end
      TX_R: begin
        sym_d = PCS_SYM_R;
        tx_st_d = TX_IDLE;
      end
      default: tx_st_d = TX_IDLE;
    endcase
    if (byp_coder) begin
      sym_d = {mac_tx.er, mac_tx.d}; // [RULE10]
    end
  end

  // Side-stream scrambler, sent MSB first; the seed differs per channel
  // so neighbouring channels never run in step.
  always_comb begin
    scr_d = scr_q;
    scr_out = 5'h00;
    for (int i = 4; i >= 0; i--) begin
      scr_out[i] = sym_d[i] ^ scr_d[10] ^ scr_d[8]; // [RULE17]
      scr_d = {scr_d[9:0], scr_d[10] ^ scr_d[8]};
    end
  end

  wire logic scr_on = !byp_scr && !spd10 && !fiber; // [RULE18] [RULE19]

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_st_q <= TX_IDLE;
      scr_q <= SCR_SEED;
      tx_sym <= PCS_SYM_IDLE;
    end else begin
      tx_st_q <= spd10 ? TX_IDLE : tx_st_d;
      scr_q <= scr_d;
      tx_sym <= scr_on ? scr_out : sym_d; // [RULE19]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Slow transmit: Manchester cells, one half-bit per cycle.

  logic [3:0] mt_sh_q;
  logic [2:0] mt_ph_q;
  logic mt_act_q;
  logic [2:0] soi_q;

  wire logic mt_ready = !mt_act_q || (mt_ph_q == 3'd7);
  wire logic mt_bit = mt_sh_q[mt_ph_q[2:1]];
  assign mac_tx_ready = spd10 ? mt_ready : 1'b1;

  // The gap is left undriven; only the closing pulse follows a frame.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mt_sh_q <= 4'h0;
      mt_ph_q <= 3'd0;
      mt_act_q <= 1'b0;
      soi_q <= 3'd0;
      man_tx <= 1'b0;
      man_tx_oe <= 1'b0;
    end else begin
      mt_ph_q <= mt_ph_q + 3'd1;
      if (soi_q != 3'd0) begin
        soi_q <= soi_q - 3'd1;
      end
      if (spd10 && mt_ready && mac_tx.en) begin
        mt_sh_q <= mac_tx.d;
        mt_ph_q <= 3'd0;
        mt_act_q <= 1'b1;
      end else if (mt_ready && mt_act_q) begin
        mt_act_q <= 1'b0;
        soi_q <= 3'(PCS_SOI_HALF); // [RULE9]
      end
      // Inverted value first, true value second. [RULE8]
      man_tx <= mt_act_q ? (mt_ph_q[0] ? mt_bit : !mt_bit) : 1'b1;
      man_tx_oe <= mt_act_q || (soi_q != 3'd0); // [RULE9]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fast receive: descrambler and its supervision.

  logic [10:0] ds_q, ds_d;
  logic [5:0] acq_q;
  logic [4:0] ones_q;
  logic seen_q;
  logic [WIN_W-1:0] win_q;

  wire logic ds_on = !byp_scr && !spd10 && !fiber; // [RULE18] [RULE20]
  wire logic ks = ds_q[10] ^ ds_q[8];
  wire logic obs = !ln; // Keystream as seen during idle.
  wire logic rbit = ds_on ? (ln ^ ks) : ln; // [RULE20]
  wire logic run_hit = rbit && (ones_q == 5'(PCS_IDLE_RUN - 1));
  wire logic win_end = (win_q == WIN_W'(SYNC_WIN_CYC - 1));
  wire logic acq_done = (acq_q == 6'(PCS_ACQ_MATCH - 1)) && (ks == obs);
  assign ds_d = synced_q ? {ds_q[9:0], ks} : {ds_q[9:0], obs};
  assign loss_of_sync = !synced_q; // [RULE23]

  // Acquire on the idle keystream; keep sync on idle runs. [RULE22]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ds_q <= 11'h000;
      acq_q <= 6'd0;
      ones_q <= 5'd0;
      seen_q <= 1'b0;
      win_q <= '0;
      synced_q <= 1'b0;
    end else begin
      ds_q <= ds_d;
      ones_q <= (!rbit) ? 5'd0 : (run_hit ? ones_q : ones_q + 5'd1);
      win_q <= win_end ? '0 : win_q + WIN_W'(1);
      if (!ds_on) begin
        synced_q <= 1'b1;
        acq_q <= 6'd0;
      end else if (!synced_q) begin
        acq_q <= (ks == obs) ? acq_q + 6'd1 : 6'd0;
        if (acq_done) begin
          synced_q <= 1'b1; // [RULE23]
          acq_q <= 6'd0;
          win_q <= '0;
          seen_q <= 1'b0;
        end
      end else if (win_end) begin
        synced_q <= seen_q || run_hit; // [RULE22]
        seen_q <= 1'b0;
      end else if (run_hit) begin
        seen_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fast receive: word alignment and decoding.

  logic [8:0] sh_q;
  logic [2:0] ph_q;
  pcs_rx_e rx_st_d;
  pcs_rx_s rx_d;
  logic [4:0] dv5;

  wire logic [9:0] sh10 = {sh_q, rbit};
  wire logic [4:0] cur = sh10[4:0];
  // Boundary found at an idle-to-start edge, then held every fifth bit.
  wire logic jk_seen = (rx_st_q == RX_IDLE) && (sh10 == {PCS_SYM_IDLE,
                        PCS_SYM_J}); // [RULE21]
  wire logic bnd = synced_q && ((ph_q == 3'd4) || jk_seen); // [RULE21]
  assign dv5 = dec5(cur);

  always_comb begin
    rx_st_d = rx_st_q;
    err_evt = 3'h0;
    rx_d = '0;
    rx_d.crs = (rx_st_q != RX_IDLE);
    if (byp_coder) begin
      rx_d.crs = lpass; // [RULE11]
      rx_d.stb = bnd;
      rx_d.er = bnd && cur[4]; // Fifth bit rides on the error line.
      rx_d.d = bnd ? cur[3:0] : PCS_NIB_ZERO; // [RULE11]
      rx_st_d = RX_IDLE;
    end else if (!synced_q || spd10) begin
      rx_st_d = RX_IDLE;
    end else if (bnd) begin
      rx_d.stb = 1'b1;
      rx_d.dv = 1'b1;
      case (rx_st_q)
        RX_IDLE: begin
          rx_d.dv = (cur == PCS_SYM_J);
          rx_d.d = (cur == PCS_SYM_J) ? PCS_NIB_SSD : PCS_NIB_ZERO;
          rx_st_d = (cur == PCS_SYM_J) ? RX_K : RX_IDLE; // [RULE4]
        end
        RX_K: begin
          rx_d.d = PCS_NIB_SSD; // [RULE4]
          rx_d.er = (cur != PCS_SYM_K); // [RULE6]
          err_evt[PCS_ST_SSD_ERR] = (cur != PCS_SYM_K); // [RULE7]
          rx_st_d = RX_DATA;
        end
        RX_DATA: begin
          rx_d.d = dv5[3:0]; // [RULE1] [RULE3]
          if (cur == PCS_SYM_T) begin
            rx_st_d = RX_R; // [RULE5]
          end else if (cur == PCS_SYM_IDLE) begin
            rx_d.er = 1'b1; // [RULE6]
            err_evt[PCS_ST_ESD_ERR] = 1'b1; // [RULE7]
            rx_st_d = RX_IDLE;
          end else if (!dv5[4]) begin
            rx_d.er = 1'b1; // [RULE6]
            err_evt[PCS_ST_CODE_ERR] = 1'b1; // [RULE7]
          end
        end
        RX_R: begin
          rx_d.d = PCS_NIB_ZERO; // [RULE5]
          rx_d.er = (cur != PCS_SYM_R); // [RULE6]
          err_evt[PCS_ST_ESD_ERR] = (cur != PCS_SYM_R); // [RULE7]
          rx_st_d = RX_IDLE;
        end
        default: rx_st_d = RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Slow receive: Manchester lock and nibble assembly.

  logic m_prev_q, m_hp_q, m_lock_q;
  logic [3:0] m_tr_q, m_nib_q;
  logic [1:0] m_cnt_q, m_flat_q;

  wire logic m_tr = (ln != m_prev_q);
  wire logic m_end = !sq || (m_flat_q == 2'(PCS_NOTRANS_END - 1) && !m_tr);
  // Take the true second half.
  wire logic m_take = m_lock_q && m_hp_q;
  wire logic m_full = m_take && (m_cnt_q == 2'd3);

  // Lock on preamble; a flat stretch ends the frame.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      m_prev_q <= 1'b0;
      m_hp_q <= 1'b0;
      m_lock_q <= 1'b0;
      m_tr_q <= 4'd0;
      m_nib_q <= 4'h0;
      m_cnt_q <= 2'd0;
      m_flat_q <= 2'd0;
    end else begin
      m_prev_q <= ln;
      m_flat_q <= m_tr ? 2'd0 : m_flat_q + 2'd1;
      m_hp_q <= !m_hp_q;
      if (!spd10 || m_end) begin
        m_lock_q <= 1'b0; // [RULE9]
        m_tr_q <= 4'd0;
        m_cnt_q <= 2'd0;
      end else if (!m_lock_q) begin
        if (m_tr) begin
          m_tr_q <= m_tr_q + 4'd1;
        end
        if (m_tr && m_tr_q == 4'(PCS_LOCK_TRANS - 1)) begin
          m_lock_q <= 1'b1; // [RULE16]
          m_hp_q <= 1'b0;
        end
      end else if (m_take) begin
        m_nib_q <= {ln, m_nib_q[3:1]}; // [RULE14]
        m_cnt_q <= m_cnt_q + 2'd1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive state and controller outputs.

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_st_q <= RX_IDLE;
      sh_q <= 9'h000;
      ph_q <= 3'd0;
      mac_rx <= '0;
      rx_clk_from_line <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      sh_q <= sh10[8:0]; // [RULE14]
      ph_q <= bnd ? 3'd0 : ((ph_q == 3'd4) ? 3'd0 : ph_q + 3'd1);
      rx_clk_from_line <= clk_line_d;
      if (spd10) begin
        mac_rx.stb <= m_full && !m_end;
        mac_rx.dv <= m_lock_q && !m_end; // [RULE16]
        mac_rx.er <= 1'b0;
        mac_rx.crs <= sq;
        mac_rx.d <= (m_full && !m_end) ? {ln, m_nib_q[3:1]} : mac_rx.d;
      end else begin
        mac_rx <= rx_d; // [RULE6]
      end
    end
  end

endmodule : pcs_coding_path

// ==== bench/pcs_mac_model.sv ====
`timescale 1ns/1ps
package pcs_tb_pkg;

  // Code of each nibble, 0 to F.
  localparam logic [4:0] PCS_ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
    5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A,
    5'h1B, 5'h1C, 5'h1D};

endpackage : pcs_tb_pkg

////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pcs_mac_model (
  // Clock.
  input wire logic ref_clk,
  // Nibble interface.
  output pcs_pkg::pcs_tx_s mac_tx,
  input wire logic mac_tx_ready,
  input wire pcs_pkg::pcs_rx_s mac_rx
);
  import pcs_pkg::*;
  logic rdy_n;
  logic [4:0] rx_q[$];

  initial mac_tx = '0;

  // Ready as the next rising edge will sample it.
  always @(negedge ref_clk) rdy_n = mac_tx_ready;

  // Received nibbles, kept as {er, d}.
  always @(posedge ref_clk) begin
    if (mac_rx.stb && mac_rx.dv) begin
      rx_q.push_back({mac_rx.er, mac_rx.d});
    end
  end

  // Words go out as {er, d}.
  task automatic send(input logic [4:0] w[$]);
    foreach (w[i]) begin
      mac_tx <= {1'b1, w[i]};
      @(posedge ref_clk);
      while (!rdy_n) @(posedge ref_clk);
    end
    // Released, the bus shows the inverse.
    mac_tx <= {1'b0, ~w[w.size()-1]};
  endtask : send

endmodule : pcs_mac_model

// ==== bench/pcs_coding_path_sva.sv ====
`timescale 1ns/1ps
module pcs_coding_path_sva (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // APB register port.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Controller side.
  input wire pcs_pkg::pcs_tx_s mac_tx,
  input wire logic mac_tx_ready,
  input wire pcs_pkg::pcs_rx_s mac_rx,
  // Line side.
  input wire logic squelch_ok,
  input wire logic fiber_signal_detect,
  input wire logic link_pass,
  input wire logic [4:0] tx_sym,
  input wire logic man_tx,
  input wire logic man_tx_oe,
  input wire logic rx_clk_from_line,
  input wire logic loss_of_sync
);
  import pcs_pkg::*;
  import pcs_tb_pkg::*;
  logic [3:0] cfg_q;

  // Shadow of the mode bits.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= PCS_CFG_RST;
    end else if (psel && penable && pwrite && paddr == PCS_CFG_OFS) begin
      cfg_q <= pwdata[3:0];
    end
  end

  // Mode decodes.
  wire fast = !cfg_q[PCS_CFG_SPEED10];
  wire plain = fast && cfg_q[PCS_CFG_BYP_SCR] && !cfg_q[PCS_CFG_BYP_CODER];
  wire raw = fast && cfg_q[PCS_CFG_BYP_SCR] && cfg_q[PCS_CFG_BYP_CODER];
  wire acc = psel && penable;
  wire mapped = paddr == PCS_CFG_OFS || paddr == PCS_STAT_OFS;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////
  chk_apb_answer: assert property (pready && pslverr == (acc && !mapped))
    else $error("apb answer wrong");
  chk_start_pair: assert property (
    plain && $rose(mac_tx.en) |=> tx_sym == PCS_SYM_J ##1 tx_sym == PCS_SYM_K)
    else $error("start pair wrong");
  chk_end_pair: assert property (plain && $fell(mac_tx.en) |=>
    tx_sym == PCS_SYM_T ##1 tx_sym == PCS_SYM_R ##1 tx_sym == PCS_SYM_IDLE)
    else $error("end pair wrong");
  chk_data_code: assert property (plain && mac_tx.en &&
    $past(mac_tx.en) && $past(mac_tx.en, 2) |=> tx_sym == ($past(mac_tx.er)
    ? PCS_SYM_H : PCS_ENC[$past(mac_tx.d)]))
    else $error("data code wrong");
  chk_raw_word: assert property (
    raw && $past(raw) |-> tx_sym == $past({mac_tx.er, mac_tx.d}))
    else $error("raw word altered");
  chk_sync_stat: assert property (
    acc && !pwrite && paddr == PCS_STAT_OFS |->
    prdata[PCS_ST_LOSS_SYNC] == $past(loss_of_sync))
    else $error("sync status wrong");
  chk_cell_halves: assert property (!fast && mac_tx_ready && mac_tx.en
    |=> ##1 man_tx == !$past(mac_tx.d[0], 2) ##1
    man_tx == $past(mac_tx.d[0], 3) && man_tx_oe)
    else $error("cell halves wrong");
  chk_idle_pulse: assert property (
    $fell(man_tx_oe) |-> $past(man_tx) && $past(man_tx, 4))
    else $error("closing pulse missing");
  chk_raw_crs: assert property (
    (raw && link_pass) [*5] |-> mac_rx.crs)
    else $error("carrier dropped");
  chk_clk_local: assert property (
    (!cfg_q[PCS_CFG_FIBER] && !squelch_ok) [*4] |-> !rx_clk_from_line)
    else $error("clock not local");
  chk_clk_fiber: assert property (
    (cfg_q[PCS_CFG_FIBER] && fiber_signal_detect) [*4] |-> rx_clk_from_line)
    else $error("fiber clock wrong");
  chk_clk_slow: assert property (
    (!fast && squelch_ok) [*4] |-> rx_clk_from_line)
    else $error("slow clock wrong");

  // Main scenarios reached.
  cover property (plain && $rose(mac_tx.en));
  cover property ($rose(man_tx_oe));
  cover property (acc && pslverr);

endmodule : pcs_coding_path_sva

// ==== bench/pcs_coding_path_tb.sv ====
`timescale 1ns/1ps
module pcs_coding_path_tb;
  import pcs_pkg::*;
  import pcs_tb_pkg::*;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic line_rx, squelch_ok, eq_settled, fiber_signal_detect, link_pass;
  logic mac_tx_ready, man_tx, man_tx_oe, rx_clk_from_line, loss_of_sync;
  logic [4:0] tx_sym;
  logic [4:0] txq[$], w[$], e[$];
  pcs_tx_s mac_tx;
  pcs_rx_s mac_rx;
  int n_fail, comparisons, n_oe;

  // Short window keeps the run brief.
  pcs_coding_path #(.SYNC_WIN_CYC(200)) pcs_coding_path_inst (.ref_clk,
    .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .mac_tx, .mac_tx_ready, .mac_rx, .line_rx, .squelch_ok,
    .eq_settled, .fiber_signal_detect, .link_pass, .tx_sym, .man_tx,
    .man_tx_oe, .rx_clk_from_line, .loss_of_sync);
  pcs_mac_model pcs_mac_model_inst (.ref_clk, .mac_tx, .mac_tx_ready,
    .mac_rx);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Log outputs away from the launch edge.
  always @(negedge ref_clk) begin
    if (tx_sym !== PCS_SYM_IDLE) txq.push_back(tx_sym);
    if (man_tx_oe === 1'b1) n_oe++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cmpq(input logic [4:0] q[$], x[$]);
    chk(32'(q.size()), 32'(x.size()));
    foreach (x[i]) chk(32'(q[i]), 32'(x[i]));
  endtask : cmpq

  // One APB transfer, then an idle edge.
  task automatic apb(input logic [7:0] a, input logic wr,
                     input logic [31:0] wd);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  // Symbols onto the line, bit 4 first.
  task automatic line(input logic [4:0] s[$]);
    foreach (s[i]) for (int b = 4; b >= 0; b--) begin
      line_rx <= s[i][b];
      @(posedge ref_clk);
    end
  endtask : line

  // A frame, its sticky error bits, then clear.
  task automatic frame(input logic [4:0] s[$], input logic [31:0] st);
    line({PCS_SYM_IDLE, PCS_SYM_IDLE, PCS_SYM_IDLE, PCS_SYM_IDLE, s,
          PCS_SYM_T, PCS_SYM_R, PCS_SYM_IDLE, PCS_SYM_IDLE});
    repeat (10) @(posedge ref_clk);
    apb(PCS_STAT_OFS, 1'b0, 32'h0);
    chk(d & 32'h7, st);
    apb(PCS_STAT_OFS, 1'b1, 32'h7);
  endtask : frame

  task automatic end_of_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {squelch_ok, fiber_signal_detect, link_pass} = '0;
    line_rx = 1'b1;
    eq_settled = 1'b1;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // Reset values, unmapped read, mode read-back.
    apb(PCS_CFG_OFS, 1'b0, 32'h0);
    chk(d, 32'h0);
    apb(PCS_STAT_OFS, 1'b0, 32'h0);
    chk(d, 32'h8);
    apb(8'h10, 1'b0, 32'h0);
    chk({d[30:0], err}, 32'h1);
    apb(PCS_CFG_OFS, 1'b1, 32'h2F);
    apb(PCS_CFG_OFS, 1'b0, 32'h0);
    chk(d, 32'hF);
    // All nibbles and a halt, scrambler bypassed.
    apb(PCS_CFG_OFS, 1'b1, 32'h2);
    w = {5'h05, 5'h05};
    e = {PCS_SYM_J, PCS_SYM_K};
    for (int i = 0; i < 16; i++) begin
      w.push_back(5'(i));
      e.push_back(PCS_ENC[i]);
    end
    w.push_back(5'h17);
    e = {e, PCS_SYM_H, PCS_SYM_T, PCS_SYM_R};
    txq = {};
    pcs_mac_model_inst.send(w);
    repeat (8) @(posedge ref_clk);
    cmpq(txq, e);
    // Raw words unchanged; carrier follows link.
    apb(PCS_CFG_OFS, 1'b1, 32'h3);
    link_pass <= 1'b1;
    e = {5'h13, 5'h00, 5'h0A};
    txq = {};
    pcs_mac_model_inst.send(e);
    repeat (8) @(posedge ref_clk);
    cmpq(txq[1:3], e);
    chk(32'(mac_rx.crs), 32'h1);
    // Frames: bad code, bad K, idle in data.
    apb(PCS_CFG_OFS, 1'b1, 32'h2);
    squelch_ok <= 1'b1;
    apb(PCS_STAT_OFS, 1'b1, 32'h7);
    pcs_mac_model_inst.rx_q = {};
    frame({PCS_SYM_J, PCS_SYM_K, PCS_ENC[3], PCS_ENC[10], 5'h00}, 32'h4);
    cmpq(pcs_mac_model_inst.rx_q,
         {5'h05, 5'h05, 5'h03, 5'h0A, 5'h10, 5'h00, 5'h00});
    pcs_mac_model_inst.rx_q = {};
    frame({PCS_SYM_J, PCS_ENC[0], PCS_ENC[5]}, 32'h1);
    cmpq(pcs_mac_model_inst.rx_q,
         {5'h05, 5'h15, 5'h05, 5'h00, 5'h00});
    frame({PCS_SYM_J, PCS_SYM_K, PCS_ENC[1], PCS_SYM_IDLE}, 32'h2);
    // Slow: two nibbles, then the closing pulse.
    apb(PCS_CFG_OFS, 1'b1, 32'h4);
    n_oe = 0;
    pcs_mac_model_inst.send({5'h05, 5'h0A});
    repeat (30) @(posedge ref_clk);
    chk(32'(n_oe), 32'd20);
    chk(32'(rx_clk_from_line), 32'h1);
    squelch_ok <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(32'(rx_clk_from_line), 32'h0);
    // Scrambled idle is not all ones.
    apb(PCS_CFG_OFS, 1'b1, 32'h0);
    txq = {};
    repeat (20) @(posedge ref_clk);
    chk(32'(txq.size() > 5), 32'h1);
    // Fiber clock follows signal detect.
    apb(PCS_CFG_OFS, 1'b1, 32'h8);
    fiber_signal_detect <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(32'(rx_clk_from_line), 32'h1);
    end_of_test();
  end

endmodule : pcs_coding_path_tb

bind pcs_coding_path pcs_coding_path_sva pcs_coding_path_sva_inst (.ref_clk,
  .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .mac_tx, .mac_tx_ready, .mac_rx, .squelch_ok,
  .fiber_signal_detect, .link_pass, .tx_sym, .man_tx, .man_tx_oe,
  .rx_clk_from_line, .loss_of_sync);
